// [ovt_cfg.svh]
// Constants of the overvoltage trip timing stage
`ifndef OVT_CFG_SVH
`define OVT_CFG_SVH
`define OVT_CLK_MHZ 10
`define OVT_TB_US 5000
`define OVT_TICK_DEF (`OVT_TB_US * `OVT_CLK_MHZ)
`define OVT_A_CTRL 8'h00
`define OVT_A_USET 8'h04
`define OVT_A_DLY 8'h08
`define OVT_A_TDIAL 8'h0C
`define OVT_A_EXPO 8'h10
`define OVT_A_REL 8'h14
`define OVT_A_VTR 8'h18
`define OVT_A_STAT 8'h1C
`define OVT_A_REMAIN 8'h20
`define OVT_A_EXPECT 8'h24
`define OVT_A_RA 8'h28
`define OVT_A_RB 8'h2C
`define OVT_A_RC 8'h30
`define OVT_A_RALL 8'h34
`define OVT_A_PRIM 8'h38
`define OVT_CTRL_RST 32'h0000_0111
`define OVT_USET_RST 16'h2904
`define OVT_DLY_RST 32'h0000_0008
`define OVT_TDIAL_RST 16'h0005
`define OVT_EXPO_RST 16'h0064
`define OVT_REL_RST 32'h0000_000C
`define OVT_VTR_RST 16'h0001
`define OVT_PCT 32'h0000_0064
`define OVT_DROP_PCT 32'h0000_0061
`define OVT_Q_ONE 32'h0000_0100
`define OVT_Q_SH 8
`define OVT_STEP_PER_10MS 32'h0000_0002
`define OVT_DT 2'h1
`define OVT_INVERSE_DELAY_MODE 2'h2
`define OVT_M_ON 3'h1
`define OVT_M_BLK 3'h2
`define OVT_M_TEST 3'h3
`define OVT_M_TBLK 3'h4
`define OVT_M_OFF 3'h5
`define OVT_DIV_N 32
`endif

// [ovt_pkg.sv]
// Types of the overvoltage trip timing stage
package ovt_pkg;
  typedef struct packed {
    logic [15:0] c;
    logic [15:0] b;
    logic [15:0] a;
  } ovt_volt_s;
  typedef struct packed {
    logic [2:0] fault;
    ovt_volt_s volt;
  } ovt_evt_s;
  typedef enum logic [2:0] {
    OVT_IDLE = 3'b000,
    OVT_RAT = 3'b001,
    OVT_QR = 3'b011,
    OVT_POW = 3'b010,
    OVT_TIME = 3'b110,
    OVT_EVAL = 3'b111
  } ovt_state_e;
endpackage

// [ovt_div.sv]
// Serial restoring divider, one quotient bit per clock
`timescale 1ns/1ns
`include "ovt_cfg.svh"
module ovt_div (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request
  input wire logic start,
  input wire logic [31:0] num,
  input wire logic [31:0] den,
  // Result
  output logic done,
  output logic [31:0] quo
);
  logic [31:0] rem_ff, quo_ff;
  logic [5:0] cnt_ff;
  logic busy_ff, done_ff;
  wire [32:0] sh_w = {rem_ff, quo_ff[31]};
  wire ge_w = sh_w >= {1'b0, den};
  wire [32:0] sub_w = sh_w - {1'b0, den};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_ff <= 32'h0000_0000;
      quo_ff <= 32'h0000_0000;
      cnt_ff <= 6'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        rem_ff <= 32'h0000_0000;
        quo_ff <= num;
        cnt_ff <= 6'(`OVT_DIV_N);
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        rem_ff <= ge_w ? sub_w[31:0] : sh_w[31:0];
        quo_ff <= {quo_ff[30:0], ge_w};
        cnt_ff <= cnt_ff - 6'h01;
        busy_ff <= cnt_ff != 6'h01;
        done_ff <= cnt_ff == 6'h01;
      end
    end
  end
  // Zero divisor gives all ones, which reads as never tripping
  assign quo = quo_ff;
  assign done = done_ff;
endmodule

// [ovt_cnt.sv]
// Saturating step counter
`timescale 1ns/1ns
module ovt_cnt (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clr,
  input wire logic inc,
  // Count
  output logic [31:0] q
);
  logic [31:0] q_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= 32'h0000_0000;
    end else if (clr) begin
      q_ff <= 32'h0000_0000;
    end else if (inc && q_ff != 32'hFFFF_FFFF) begin
      q_ff <= q_ff + 32'h0000_0001;
    end
  end
  assign q = q_ff;
endmodule

// [ovt_stage.sv]
// Overvoltage stage: pick-up, blocking, trip timing, APB registers
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "ovt_cfg.svh"
// Functional notes
// [RULE1] Blocking input sampled once at each program cycle start.
// [RULE2] Pick-up without blocking raises START and starts timing.
// [RULE3] Pick-up with blocking raises BLOCKED; no START, no timing.
// [RULE4] Blocking after START drops START and runs release handling.
// [RULE5] Blocking emits stamped event and display event with voltages, fault.
// [RULE6] Blocking must arrive 5 ms before the delay expires.
// [RULE7] Instant operation trips together with START.
// [RULE8] Fixed delay trips after the set delay, whatever the overshoot.
// [RULE9] Inverse time is dial over ratio to the exponent minus one.
// [RULE10] Delay type 1 is fixed, 2 inverse; fixed by default.
// [RULE11] Fixed delay in 5 ms steps, default 40 ms; zero is instant.
// [RULE12] Time dial in 10 ms steps, default 50 ms, inverse only.
// [RULE13] Exponent applied to the ratio, default one, inverse only.
// [RULE14] Signed remaining time to trip in 5 ms steps.
// [RULE15] Expected operating time, recomputed each cycle in inverse mode.
// [RULE16] Per-channel and overall voltage ratios in hundredths.
// [RULE17] Behaviour readout: 1 on, 2 blocked, 3 test, 4 test blocked, 5 off.
// [RULE18] Primary pick-up level in 0.1 V from threshold and scaling.
// [RULE19] With forcing enabled a software bit drives blocking.
// [RULE20] Drop-out only below 97 percent of threshold.
// [RULE21] Criterion 0, 1, 2 needs one, two, three voltages; default one.
// [RULE22] Delayed release holds START for the release delay.
// [RULE23] Time counted in 5 ms steps; trip when count reaches time.
module ovt_stage import ovt_pkg::*; #(
  parameter int TICK_CYC = `OVT_TICK_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement and blocking matrix
  input wire ovt_volt_s meas,
  input wire logic meas_blk,
  // Stage outputs
  output logic start,
  output logic trip,
  output logic blocked,
  // Blocking events
  output logic blk_evt,
  output logic disp_evt,
  output ovt_evt_s evt_data
);
  ovt_state_e st_ff, nxt_st;
  logic [31:0] ctrl_ff, dly_ff, rel_ff, prdata_ff, tick_ff;
  logic [15:0] uset_ff, tdial_ff, expo_ff, vtr_ff;
  logic pready_ff, pslverr_ff, blk_s_ff;
  logic start_ff, trip_ff, blocked_ff, pu_ff, rls_ff;
  logic blk_evt_ff, disp_evt_ff;
  ovt_evt_s evt_ff;
  ovt_volt_s v_ff;
  logic [1:0] idx_ff;
  logic [15:0] ra_ff, rb_ff, rc_ff, rall_ff, pacc_ff;
  logic [31:0] qr_ff, pw_ff, tinv_ff, expect_ff, remain_ff;
  logic dstart_ff;
  // Register fields
  wire [1:0] dtype_w = ctrl_ff[1:0];
  wire [1:0] crit_w = ctrl_ff[3:2];
  wire rel_en_w = ctrl_ff[4];
  wire force_en_w = ctrl_ff[5];
  wire force_blk_w = ctrl_ff[6];
  wire [2:0] mode_w = ctrl_ff[10:8];
  // APB decode
  wire setup_w = psel & ~penable;
  wire wr_w = psel & penable & pready_ff & pwrite;
  wire tick_w = tick_ff == 32'(TICK_CYC - 1);
  wire blk_src_w = force_en_w ? force_blk_w : meas_blk; // [RULE19]
  wire inverse_delay_mode_w = dtype_w == `OVT_INVERSE_DELAY_MODE; // [RULE10]
  wire instant_w = !inverse_delay_mode_w && dly_ff == 32'h0000_0000; // [RULE11]
  wire off_w = mode_w == `OVT_M_OFF;
  // Divider feed
  wire div_done_w;
  wire [31:0] div_q_w;
  wire [15:0] vsel_w = idx_ff == 2'h0 ? v_ff.a :
                       idx_ff == 2'h1 ? v_ff.b : v_ff.c;
  wire [15:0] vmax_w = (v_ff.a >= v_ff.b && v_ff.a >= v_ff.c) ? v_ff.a :
                       (v_ff.b >= v_ff.c) ? v_ff.b : v_ff.c;
  wire [31:0] qone_w = `OVT_Q_ONE;
  wire [31:0] den_t_w = pw_ff - qone_w;
  wire [31:0] num_w = st_ff == OVT_RAT ? 32'(vsel_w) * `OVT_PCT :
                      st_ff == OVT_QR ? 32'(vmax_w) << `OVT_Q_SH :
                      (32'(tdial_ff) * `OVT_STEP_PER_10MS) << `OVT_Q_SH;
  wire [31:0] den_w = st_ff == OVT_TIME ? den_t_w : 32'(uset_ff);
  wire [63:0] pmul_w = 64'(pw_ff) * 64'(qr_ff);
  wire [63:0] pnxt_w = pmul_w >> `OVT_Q_SH;
  wire [31:0] psat_w = |pnxt_w[63:32] ? 32'hFFFF_FFFF : pnxt_w[31:0];
  // Pick-up comparison with fixed hysteresis
  wire [31:0] up_lvl_w = 32'(uset_ff) * `OVT_PCT;
  wire [31:0] dn_lvl_w = 32'(uset_ff) * `OVT_DROP_PCT;
  wire [2:0] over_w = {32'(v_ff.c) * `OVT_PCT > up_lvl_w,
                       32'(v_ff.b) * `OVT_PCT > up_lvl_w,
                       32'(v_ff.a) * `OVT_PCT > up_lvl_w};
  wire [2:0] hold_w = {32'(v_ff.c) * `OVT_PCT >= dn_lvl_w,
                       32'(v_ff.b) * `OVT_PCT >= dn_lvl_w,
                       32'(v_ff.a) * `OVT_PCT >= dn_lvl_w}; // [RULE20]
  wire [1:0] nover_w = 2'(over_w[0]) + 2'(over_w[1]) + 2'(over_w[2]);
  wire [1:0] nhold_w = 2'(hold_w[0]) + 2'(hold_w[1]) + 2'(hold_w[2]);
  wire [1:0] need_w = crit_w == 2'h2 ? 2'h3 :
                      crit_w == 2'h1 ? 2'h2 : 2'h1; // [RULE21]
  wire pu_w = !off_w && (pu_ff ? nhold_w >= need_w : nover_w >= need_w);
  // Operating time in 5 ms steps
  wire [31:0] top_w = inverse_delay_mode_w ? tinv_ff : dly_ff; // [RULE8]
  wire eval_w = st_ff == OVT_EVAL;
  wire [31:0] op_q_w, rel_q_w;
  wire run_w = eval_w && pu_w && !blk_s_ff;
  wire rel_run_w = eval_w && !run_w && (start_ff || rls_ff);
  wire rel_end_w = rel_q_w + 32'h0000_0001 >= rel_ff;
  // Trip when the count including this step reaches the time
  wire trip_w = run_w && (instant_w || op_q_w + 32'h0000_0001 >= top_w);
  wire op_clr_w = eval_w && (off_w || (!run_w && (!rls_ff || rel_end_w)));
  wire [31:0] prim_w = 32'(uset_ff) * 32'(vtr_ff);
  wire [2:0] beh_w = blocked_ff && mode_w == `OVT_M_ON ? `OVT_M_BLK :
                     blocked_ff && mode_w == `OVT_M_TEST ? `OVT_M_TBLK :
                     mode_w; // [RULE17]
  wire [31:0] stat_w = {21'h0, beh_w, 5'h0, blocked_ff, trip_ff, start_ff};
  // Read mux; unmapped reads zero with an error
  wire [31:0] rd_w =
    paddr == `OVT_A_CTRL ? ctrl_ff : paddr == `OVT_A_USET ? 32'(uset_ff) :
    paddr == `OVT_A_DLY ? dly_ff : paddr == `OVT_A_TDIAL ? 32'(tdial_ff) :
    paddr == `OVT_A_EXPO ? 32'(expo_ff) : paddr == `OVT_A_REL ? rel_ff :
    paddr == `OVT_A_VTR ? 32'(vtr_ff) : paddr == `OVT_A_STAT ? stat_w :
    paddr == `OVT_A_REMAIN ? remain_ff :
    paddr == `OVT_A_EXPECT ? expect_ff : paddr == `OVT_A_RA ? 32'(ra_ff) :
    paddr == `OVT_A_RB ? 32'(rb_ff) : paddr == `OVT_A_RC ? 32'(rc_ff) :
    paddr == `OVT_A_RALL ? 32'(rall_ff) :
    paddr == `OVT_A_PRIM ? prim_w : 32'h0000_0000; // [RULE18]
  wire hit_w = paddr[1:0] == 2'h0 && paddr <= `OVT_A_PRIM;
  wire ro_w = paddr >= `OVT_A_STAT;
  ovt_div u_div (
    .pclk(pclk), .presetn(presetn), .start(dstart_ff),
    .num(num_w), .den(den_w), .done(div_done_w), .quo(div_q_w)
  );
  ovt_cnt u_op (
    .pclk(pclk), .presetn(presetn), .clr(op_clr_w),
    .inc(run_w), .q(op_q_w)
  ); // [RULE23]
  ovt_cnt u_rel (
    .pclk(pclk), .presetn(presetn), .clr(run_w || !rls_ff),
    .inc(rel_run_w && rls_ff), .q(rel_q_w)
  );
  // Calculation sequence, one pass per program cycle
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      OVT_IDLE: if (tick_w) nxt_st = OVT_RAT;
      OVT_RAT: if (div_done_w && idx_ff == 2'h2) nxt_st = OVT_QR;
      OVT_QR: if (div_done_w) nxt_st = OVT_POW;
      OVT_POW: if (pacc_ff >= expo_ff) nxt_st = OVT_TIME; // [RULE13]
      OVT_TIME: if (div_done_w) nxt_st = OVT_EVAL;
      OVT_EVAL: nxt_st = OVT_IDLE;
      default: nxt_st = OVT_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      ctrl_ff <= `OVT_CTRL_RST;
      uset_ff <= `OVT_USET_RST;
      dly_ff <= `OVT_DLY_RST;
      tdial_ff <= `OVT_TDIAL_RST; // [RULE12]
      expo_ff <= `OVT_EXPO_RST;
      rel_ff <= `OVT_REL_RST;
      vtr_ff <= `OVT_VTR_RST;
    end else begin
      pready_ff <= setup_w;
      pslverr_ff <= setup_w && (!hit_w || (pwrite && ro_w));
      prdata_ff <= setup_w && !pwrite ? rd_w : 32'h0000_0000;
      if (wr_w && !pslverr_ff) begin
        case (paddr)
          `OVT_A_CTRL: ctrl_ff <= pwdata;
          `OVT_A_USET: uset_ff <= pwdata[15:0];
          `OVT_A_DLY: dly_ff <= pwdata;
          `OVT_A_TDIAL: tdial_ff <= pwdata[15:0];
          `OVT_A_EXPO: expo_ff <= pwdata[15:0];
          `OVT_A_REL: rel_ff <= pwdata;
          `OVT_A_VTR: vtr_ff <= pwdata[15:0];
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= OVT_IDLE;
      tick_ff <= 32'h0000_0000;
      blk_s_ff <= 1'b0;
      v_ff <= '0;
      idx_ff <= 2'h0;
      dstart_ff <= 1'b0;
      pacc_ff <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      tick_ff <= tick_w ? 32'h0000_0000 : tick_ff + 32'h0000_0001;
      dstart_ff <= (tick_w && st_ff == OVT_IDLE) ||
                   (div_done_w && st_ff == OVT_RAT) ||
                   (st_ff == OVT_POW && pacc_ff >= expo_ff);
      if (tick_w && st_ff == OVT_IDLE) begin
        blk_s_ff <= blk_src_w; // [RULE1]
        v_ff <= meas;
        idx_ff <= 2'h0;
      end
      if (div_done_w && st_ff == OVT_RAT) idx_ff <= idx_ff + 2'h1;
      pacc_ff <= st_ff == OVT_POW ? pacc_ff + 16'(`OVT_PCT) : 16'h0000;
    end
  end
  // Ratios, power and inverse time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ra_ff <= 16'h0000;
      rb_ff <= 16'h0000;
      rc_ff <= 16'h0000;
      rall_ff <= 16'h0000;
      qr_ff <= 32'h0000_0000;
      pw_ff <= 32'h0000_0000;
      tinv_ff <= 32'hFFFF_FFFF;
    end else begin
      if (div_done_w && st_ff == OVT_RAT) begin
        if (idx_ff == 2'h0) ra_ff <= div_q_w[15:0]; // [RULE16]
        if (idx_ff == 2'h1) rb_ff <= div_q_w[15:0];
        if (idx_ff == 2'h2) rc_ff <= div_q_w[15:0];
      end
      if (div_done_w && st_ff == OVT_QR) qr_ff <= div_q_w;
      if (st_ff == OVT_QR) pw_ff <= qone_w;
      else if (st_ff == OVT_POW && pacc_ff < expo_ff) pw_ff <= psat_w;
      if (div_done_w && st_ff == OVT_TIME) tinv_ff <= div_q_w; // [RULE9]
      if (eval_w) rall_ff <= ra_ff >= rb_ff && ra_ff >= rc_ff ? ra_ff :
                             rb_ff >= rc_ff ? rb_ff : rc_ff;
    end
  end
  // Start, trip, blocked, release and events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_ff <= 1'b0;
      start_ff <= 1'b0;
      trip_ff <= 1'b0;
      blocked_ff <= 1'b0;
      rls_ff <= 1'b0;
      blk_evt_ff <= 1'b0;
      disp_evt_ff <= 1'b0;
      evt_ff <= '0;
      expect_ff <= 32'h0000_0000;
      remain_ff <= 32'h0000_0000;
    end else begin
      blk_evt_ff <= 1'b0;
      disp_evt_ff <= 1'b0;
      if (eval_w) begin
        pu_ff <= pu_w;
        expect_ff <= instant_w ? 32'h0000_0000 : top_w; // [RULE15]
        blocked_ff <= pu_w && blk_s_ff; // [RULE3]
        start_ff <= run_w ||
                    (start_ff && !blk_s_ff && rel_en_w &&
                     !rel_end_w && !off_w); // [RULE2] [RULE4] [RULE22]
        rls_ff <= !run_w && !off_w && !(rls_ff && rel_end_w) &&
                  (start_ff || rls_ff); // [RULE4]
        trip_ff <= trip_w; // [RULE7] [RULE8] [RULE23]
        remain_ff <= run_w ? top_w - op_q_w - 32'h0000_0001 :
                     32'h0000_0000; // [RULE14]
        if (pu_w && blk_s_ff && !blocked_ff) begin
          blk_evt_ff <= 1'b1; // [RULE5]
          disp_evt_ff <= 1'b1;
          evt_ff <= '{fault: over_w, volt: v_ff};
        end
      end
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign start = start_ff;
  assign trip = trip_ff;
  assign blocked = blocked_ff;
  assign blk_evt = blk_evt_ff;
  assign disp_evt = disp_evt_ff;
  assign evt_data = evt_ff;
  // Checks
  property p_blk_sample;
    @(posedge pclk) disable iff (!presetn)
    (tick_w && st_ff == OVT_IDLE) |=> blk_s_ff == $past(blk_src_w);
  endproperty
  a_blk_sample: assert property (p_blk_sample) // [RULE1]
    else $error("blocking not sampled at program cycle start");
  property p_no_both;
    @(posedge pclk) disable iff (!presetn) !(start_ff && blocked_ff);
  endproperty
  a_no_both: assert property (p_no_both) // [RULE3]
    else $error("start and blocked together");
  property p_start;
    @(posedge pclk) disable iff (!presetn)
    (eval_w && pu_w && !blk_s_ff) |=> start_ff && !blocked_ff;
  endproperty
  a_start: assert property (p_start) // [RULE2]
    else $error("start missing on unblocked pick-up");
  property p_blk_drop;
    @(posedge pclk) disable iff (!presetn)
    (eval_w && start_ff && blk_s_ff && !rls_ff && !off_w) |=>
    !start_ff ##0 rls_ff;
  endproperty
  a_blk_drop: assert property (p_blk_drop) // [RULE4]
    else $error("start kept under blocking");
  property p_evt;
    @(posedge pclk) disable iff (!presetn)
    $rose(blocked_ff) |-> blk_evt_ff && disp_evt_ff && evt_ff.volt == v_ff;
  endproperty
  a_evt: assert property (p_evt) // [RULE5]
    else $error("blocking event missing");
  property p_instant;
    @(posedge pclk) disable iff (!presetn)
    ($rose(start_ff) && $past(instant_w)) |-> trip_ff;
  endproperty
  a_instant: assert property (p_instant) // [RULE7]
    else $error("instant trip late");
  property p_trip_time;
    @(posedge pclk) disable iff (!presetn)
    $rose(trip_ff) && !$past(instant_w) |-> $past(op_q_w) + 1 >= $past(top_w);
  endproperty
  a_trip_time: assert property (p_trip_time) // [RULE8] [RULE23]
    else $error("trip before operating time");
  property p_off;
    @(posedge pclk) disable iff (!presetn)
    (eval_w && off_w) |=> !start_ff && !trip_ff && !blocked_ff;
  endproperty
  a_off: assert property (p_off) // [RULE17]
    else $error("stage active while off");
  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (setup_w && !hit_w) |=> pready_ff && pslverr_ff;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  c_trip: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(trip_ff));
  c_block: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(blocked_ff));
  c_release: cover property (@(posedge pclk) disable iff (!presetn)
    rls_ff && start_ff);
endmodule

// [ovt_front.sv]
// Model of the measurement front end and blocking matrix
`timescale 1ns/1ns
module ovt_front import ovt_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Values commanded by the bench
  input wire ovt_volt_s want,
  input wire logic want_blk,
  // Stage side
  output ovt_volt_s meas,
  output logic meas_blk
);
  ovt_volt_s meas_ff;
  logic blk_ff;
  // Registered, so values move only right after a clock edge or when reset is asserted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_ff <= '0;
      blk_ff <= 1'b0;
    end else begin
      meas_ff <= want;
      blk_ff <= want_blk;
    end
  end
  assign meas = meas_ff;
  assign meas_blk = blk_ff;
endmodule

// [ovt_stage_tb.sv]
// Self-checking bench of the overvoltage stage over APB
`timescale 1ns/1ns
`include "ovt_cfg.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: %h expected %h", $time, a, e); end end
module ovt_stage_tb import ovt_pkg::*; ;
  // Short program cycle; calculation takes about 175 cycles
  localparam int TK = 300;
  localparam int S = 0;
  localparam int T = 1;
  localparam int B = 2;
  localparam int E = 3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic start, trip, blocked, blk_evt, disp_evt, want_blk, meas_blk;
  logic [3:0] o;
  ovt_volt_s want, meas;
  ovt_evt_s evt_data;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rv [7] = '{`OVT_CTRL_RST, 32'(`OVT_USET_RST), `OVT_DLY_RST,
    32'(`OVT_TDIAL_RST), 32'(`OVT_EXPO_RST), `OVT_REL_RST, 32'(`OVT_VTR_RST)};
  assign o = {blk_evt, blocked, trip, start};

  ovt_stage #(.TICK_CYC(TK)) i_ovt_stage (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .meas_blk(meas_blk), .start(start), .trip(trip),
    .blocked(blocked), .blk_evt(blk_evt), .disp_evt(disp_evt),
    .evt_data(evt_data));
  ovt_front i_ovt_front (.pclk(pclk), .presetn(presetn), .want(want),
    .want_blk(want_blk), .meas(meas), .meas_blk(meas_blk));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One APB transfer; a free edge follows so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  task automatic wfor(input int w, input logic v);
    for (int i = 0; i < 1000 && o[w] !== v; i++) @(posedge pclk);
    `CHK(o[w], v)
  endtask

  task automatic setm(input logic [15:0] a, input logic [15:0] b,
                      input logic [15:0] c, input logic k);
    want <= {c, b, a};
    want_blk <= k;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    want = '0;
    want_blk = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) rchk(8'(i * 4), rv[i]);
    rchk(`OVT_A_PRIM, 32'(`OVT_USET_RST));
    apb(1'b1, `OVT_A_VTR, 32'h0000_0003);
    rchk(`OVT_A_PRIM, 32'(`OVT_USET_RST) * 3);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, `OVT_A_STAT, 32'h0000_0000);
    `CHK(err, 1'b1)
    // Fixed delay of two steps, no delayed release
    apb(1'b1, `OVT_A_CTRL, 32'h0000_0101);
    apb(1'b1, `OVT_A_DLY, 32'h0000_0002);
    setm(16'h5208, 16'h0000, 16'h0000, 1'b0);
    wfor(S, 1'b1);
    `CHK(trip, 1'b0)
    repeat (TK - 10) @(posedge pclk);
    `CHK(trip, 1'b0)
    repeat (20) @(posedge pclk);
    `CHK(trip, 1'b1)
    rchk(`OVT_A_RA, 32'h0000_00C8);
    rchk(`OVT_A_RB, 32'h0000_0000);
    rchk(`OVT_A_RALL, 32'h0000_00C8);
    rchk(`OVT_A_STAT, 32'h0000_0103);
    // Between 97 and 100 percent the stage holds
    setm(16'h2838, 16'h0000, 16'h0000, 1'b0);
    repeat (2 * TK) @(posedge pclk);
    `CHK(start, 1'b1)
    setm(16'h2710, 16'h0000, 16'h0000, 1'b0);
    repeat (2 * TK) @(posedge pclk);
    `CHK({start, trip}, 2'b00)
    // Zero delay behaves as instant
    apb(1'b1, `OVT_A_DLY, 32'h0000_0000);
    setm(16'h5208, 16'h0000, 16'h0000, 1'b0);
    wfor(S, 1'b1);
    `CHK(trip, 1'b1)
    // Delayed release of two steps holds START
    apb(1'b1, `OVT_A_CTRL, 32'h0000_0111);
    apb(1'b1, `OVT_A_REL, 32'h0000_0002);
    setm(16'h0000, 16'h0000, 16'h0000, 1'b0);
    repeat (600) @(posedge pclk);
    `CHK(start, 1'b1)
    repeat (4 * TK) @(posedge pclk);
    `CHK(start, 1'b0)
    // Blocking present at pick-up
    apb(1'b1, `OVT_A_CTRL, 32'h0000_0101);
    apb(1'b1, `OVT_A_DLY, 32'h0000_0008);
    setm(16'h5208, 16'h0000, 16'h0000, 1'b1);
    wfor(E, 1'b1);
    `CHK({disp_evt, start}, 2'b10)
    @(posedge pclk);
    `CHK(blk_evt, 1'b0)
    `CHK(evt_data, {3'b001, 16'h0000, 16'h0000, 16'h5208})
    `CHK(blocked, 1'b1)
    rchk(`OVT_A_STAT, 32'h0000_0204);
    // Test mode under blocking reads as test with blocking
    apb(1'b1, `OVT_A_CTRL, 32'h0000_0301);
    rchk(`OVT_A_STAT, 32'h0000_0404);
    repeat (9 * TK) @(posedge pclk);
    `CHK({start, trip}, 2'b00)
    // Blocking arriving after START, well ahead of expiry
    setm(16'h5208, 16'h0000, 16'h0000, 1'b0);
    wfor(S, 1'b1);
    setm(16'h5208, 16'h0000, 16'h0000, 1'b1);
    wfor(S, 1'b0);
    repeat (9 * TK) @(posedge pclk);
    `CHK(trip, 1'b0)
    // Software switch forces blocking
    setm(16'h5208, 16'h0000, 16'h0000, 1'b0);
    apb(1'b1, `OVT_A_CTRL, 32'h0000_0161);
    repeat (2 * TK) @(posedge pclk);
    `CHK({blocked, start}, 2'b10)
    // Two voltages needed, then all three
    apb(1'b1, `OVT_A_CTRL, 32'h0000_0105);
    repeat (3 * TK) @(posedge pclk);
    `CHK({blocked, start}, 2'b00)
    setm(16'h5208, 16'h5208, 16'h0000, 1'b0);
    wfor(S, 1'b1);
    apb(1'b1, `OVT_A_CTRL, 32'h0000_0109);
    repeat (3 * TK) @(posedge pclk);
    `CHK({blocked, start}, 2'b00)
    setm(16'h5208, 16'h5208, 16'h5208, 1'b0);
    wfor(S, 1'b1);
    // Inverse time at twice the threshold: 50 ms over one is 10 steps
    apb(1'b1, `OVT_A_CTRL, 32'h0000_0102);
    repeat (2 * TK) @(posedge pclk);
    rchk(`OVT_A_EXPECT, 32'h0000_000A);
    apb(1'b0, `OVT_A_REMAIN, 32'h0000_0000);
    `CHK($signed(rd) > 0 && $signed(rd) <= 10, 1'b1)
    // Dial 160 ms, power two, ratio three: 160 ms over eight
    apb(1'b1, `OVT_A_TDIAL, 32'h0000_0010);
    apb(1'b1, `OVT_A_EXPO, 32'h0000_00C8);
    setm(16'h7B0C, 16'h0000, 16'h0000, 1'b0);
    repeat (2 * TK) @(posedge pclk);
    rchk(`OVT_A_EXPECT, 32'h0000_0004);
    // Off mode silences the stage
    apb(1'b1, `OVT_A_CTRL, 32'h0000_0501);
    repeat (2 * TK) @(posedge pclk);
    rchk(`OVT_A_STAT, 32'h0000_0500);
    results();
  end
endmodule
